//--- src/shadow_buffer_pkg.sv
// package for the shadow receive/transmit buffer block
// holds register addresses, field positions, reset values and carrier types;
// assumes a 32-bit Avalon-MM byte address space
package shadow_buffer_pkg;

  // bus geometry
  localparam int          ADDR_W         = 32;         // byte address width
  localparam int          DATA_W         = 32;         // bus data width
  localparam int          FIFO_DEPTH_DEF = 16;         // default FIFO depth

  // sixteen aliased shadow locations, one 32-bit word each
  localparam logic [31:0] SHADOW_BASE    = 32'h50001130; // first alias
  localparam logic [31:0] SHADOW_LAST    = 32'h5000116c; // sixteenth alias
  localparam logic [31:0] SHADOW_2_ADDR  = 32'h50001138; // uart2_shadow_buffer_2
  localparam logic [31:0] SHADOW_3_ADDR  = 32'h5000113c; // uart2_shadow_buffer_3

  // control and status registers of this block
  localparam logic [31:0] CONTROL_ADDR     = 32'h50001180; // fifo_control and mode
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h50001184; // line_status
  localparam logic [31:0] INT_STATUS_ADDR  = 32'h50001188; // sticky events
  localparam logic [31:0] INT_MASK_ADDR    = 32'h5000118c; // event mask

  // control fields
  localparam int CTRL_FIFO_EN  = 0;                    // fifo_control bit 0
  localparam int CTRL_INFRARED = 1;                    // infrared mode select

  // line_status fields, also the layout of the event registers
  localparam int LS_RX_READY   = 0;                    // rx_data_ready
  localparam int LS_OVERRUN    = 1;                    // overrun error
  localparam int LS_TX_EMPTY   = 5;                    // tx_holding_empty
  localparam int EVENT_W       = 6;                    // bits used in event registers

  // reset values
  localparam logic [1:0]         CONTROL_RESET = 2'h0;  // fifos off, uart mode
  localparam logic [EVENT_W-1:0] EVENT_RESET   = 6'h00; // no events, all masked
  localparam logic [7:0]         BYTE_RESET    = 8'h00; // buffer contents
  localparam logic [31:0]        READ_ZERO     = 32'h00000000; // unmapped answer

  // one received byte with its strobe
  typedef struct packed {
    logic       valid;                                // one-cycle pulse
    logic [7:0] data;                                 // received byte
  } rx_byte_type;

  // one bus request as seen by the slave
  typedef struct packed {
    logic [ADDR_W-1:0] address;                       // byte address
    logic              read;                          // read request
    logic              write;                         // write request
    logic [DATA_W-1:0] writedata;                     // write data
    logic [3:0]        byteenable;                    // byte lanes
  } bus_req_type;

endpackage

//--- src/shadow_rx_tx_buffer.sv
// shadow receive buffer / transmit holding path of a uart
// assumes a deserializer that delivers bytes as one-cycle strobes and a
// serializer that pulses tx_take when it loads the byte on tx_data
`timescale 1ns/1ns
`default_nettype none

module shadow_rx_tx_buffer
  import shadow_buffer_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF                 // fifo depth, both directions
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output var  logic [DATA_W-1:0] readdata,
  output var  logic              waitrequest,
  // interrupt
  output var  logic              irq,
  // received bytes from the uart and infrared deserializers
  input  wire rx_byte_type       uart_rx,
  input  wire rx_byte_type       ir_rx,
  // transmit byte towards the serializer
  output var  logic [7:0]        tx_data,
  output var  logic              tx_valid,
  output var  logic              tx_to_infrared,
  input  wire logic              tx_take
);

  localparam int PTR_W = $clog2(DEPTH);               // pointer width
  localparam int CNT_W = PTR_W + 1;                   // occupancy width
  localparam logic [CNT_W-1:0] CNT_DEPTH = CNT_W'(DEPTH); // full mark
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);     // single slot

  // advance a fifo pointer with wrap at DEPTH
  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] r;
    r = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    return r;
  endfunction

  // true when an address falls in the aliased shadow window
  function automatic logic in_shadow(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a >= SHADOW_BASE) && (a <= SHADOW_LAST) && (a[1:0] == 2'h0);
    return hit;
  endfunction

  bus_req_type            req;                         // bundled request
  logic                   access;                      // request taken this edge
  logic                   shadow_hit;                  // request hits an alias
  logic [1:0]             control;                     // fifo enable, infrared
  logic                   fifo_en;                     // fifo_control bit 0
  logic                   infrared;                    // infrared mode
  logic                   flush;                       // fifo enable changed

  // receive buffer
  logic [7:0]             rx_mem [DEPTH];              // receive storage
  logic [PTR_W-1:0]       rx_rd;                       // head pointer
  logic [PTR_W-1:0]       rx_wr;                       // tail pointer
  logic [CNT_W-1:0]       rx_count;                    // bytes held
  rx_byte_type            rx_in;                       // selected input
  logic [CNT_W-1:0]       rx_cap;                      // capacity in this mode
  logic                   rx_pop;                      // shadow read consumes
  logic                   rx_room;                     // a slot is free
  logic                   rx_push;                     // byte stored at tail
  logic                   rx_overrun;                  // byte overwritten or lost

  // transmit buffer
  logic [7:0]             tx_mem [DEPTH];              // transmit storage
  logic [PTR_W-1:0]       tx_rd;                       // head pointer
  logic [PTR_W-1:0]       tx_wr;                       // tail pointer
  logic [CNT_W-1:0]       tx_count;                    // bytes queued
  logic [CNT_W-1:0]       tx_total;                    // queued plus outgoing
  logic                   tx_hit;                      // shadow write, low lane
  logic                   tx_push;                     // write accepted in fifo
  logic                   tx_load;                     // move head to output
  logic                   tx_empty;                    // tx_holding_empty
  logic                   tx_empty_prev;               // for the rising edge

  // status and interrupts
  logic                   overrun;                     // sticky line status bit
  logic [EVENT_W-1:0]     line_status;                 // live line status
  logic [EVENT_W-1:0]     int_status;                  // sticky events
  logic [EVENT_W-1:0]     int_mask;                    // event enables
  logic [EVENT_W-1:0]     events;                      // this cycle's events
  logic [EVENT_W-1:0]     next_int_status;             // status after this edge

  // bundle the bus signals
  assign req = '{address: address, read: read, write: write,
                 writedata: writedata, byteenable: byteenable};

  // a request is taken on the edge where waitrequest is still high;
  // the master keeps it up one more edge, where waitrequest is low,
  // so the same held request is never taken twice
  assign access     = (req.read || req.write) && waitrequest;
  assign shadow_hit = in_shadow(req.address);
  assign fifo_en    = control[CTRL_FIFO_EN];
  assign infrared   = control[CTRL_INFRARED];
  assign flush      = access && req.write && (req.address == CONTROL_ADDR) &&
                      req.byteenable[0] && (req.writedata[CTRL_FIFO_EN] != fifo_en);

  // a fifo enable change empties both buffers: pointers mean different
  // things in the two modes, so stale bytes must not leak across
  // receive side decisions
  assign rx_in      = infrared ? ir_rx : uart_rx;
  assign rx_cap     = fifo_en ? CNT_DEPTH : CNT_ONE;
  assign rx_pop     = access && req.read && shadow_hit && (rx_count != '0);
  assign rx_room    = (rx_count != rx_cap) || rx_pop;
  assign rx_push    = rx_in.valid && rx_room;
  assign rx_overrun = rx_in.valid && !rx_room;

  // transmit side decisions; the outgoing register counts as one slot,
  // so the fifo drops shadow writes once queued plus outgoing reach DEPTH
  assign tx_hit   = access && req.write && shadow_hit && req.byteenable[0];
  assign tx_total = tx_count + {{(CNT_W-1){1'b0}}, tx_valid};
  assign tx_push  = fifo_en && tx_hit && (tx_total != CNT_DEPTH);
  assign tx_load  = fifo_en && (!tx_valid || tx_take) && (tx_count != '0);
  assign tx_empty = (tx_count == '0) && !tx_valid;

  // live line status word
  always_comb begin
    line_status              = '0;
    line_status[LS_RX_READY] = (rx_count != '0);
    line_status[LS_OVERRUN]  = overrun;
    line_status[LS_TX_EMPTY] = tx_empty;
  end

  // events: new data, overrun, holding register drained;
  // the drain event fires on the rising edge of tx_holding_empty only,
  // so the idle level after reset raises no interrupt
  always_comb begin
    events              = '0;
    events[LS_RX_READY] = rx_push;
    events[LS_OVERRUN]  = rx_overrun;
    events[LS_TX_EMPTY] = tx_empty && !tx_empty_prev;
  end

  // sticky events: a read clears them, a new event in that cycle survives
  // (set wins over clear, so no event is lost to a racing read)
  always_comb begin
    next_int_status = int_status;
    if (access && req.read && (req.address == INT_STATUS_ADDR)) begin
      next_int_status = '0;
    end
    next_int_status = next_int_status | events;
  end

  // bus handshake: answer one edge after the request is seen
  // every access has exactly one wait cycle; nothing here ever stalls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else if (access) begin
      waitrequest <= 1'b0;                             // release at next edge
    end else begin
      waitrequest <= 1'b1;                             // idle, or request retired
    end
  end

  // read data, registered with the answer
  // holds its value between reads; unmapped places read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= READ_ZERO;
    end else if (access && req.read) begin
      readdata <= READ_ZERO;                           // unmapped and upper bits
      if (shadow_hit) begin
        readdata[7:0] <= rx_mem[rx_rd];
      end else if (req.address == CONTROL_ADDR) begin
        readdata[1:0] <= control;
      end else if (req.address == LINE_STATUS_ADDR) begin
        readdata[EVENT_W-1:0] <= line_status;
      end else if (req.address == INT_STATUS_ADDR) begin
        readdata[EVENT_W-1:0] <= int_status;
      end else if (req.address == INT_MASK_ADDR) begin
        readdata[EVENT_W-1:0] <= int_mask;
      end
    end
  end

  // control register: fifo enable and infrared mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= CONTROL_RESET;
    end else if (access && req.write && (req.address == CONTROL_ADDR) &&
                 req.byteenable[0]) begin
      control <= req.writedata[1:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_mask <= EVENT_RESET;
    end else if (access && req.write && (req.address == INT_MASK_ADDR) &&
                 req.byteenable[0]) begin
      int_mask <= req.writedata[EVENT_W-1:0];
    end
  end

  // sticky event bits and the level interrupt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_status <= EVENT_RESET;
      irq        <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq        <= |(next_int_status & int_mask);
    end
  end

  // overrun flag: set by a lost byte, cleared by reading line status
  // a byte lost in the very cycle of that read still leaves the flag set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun <= 1'b0;
    end else if (rx_overrun) begin
      overrun <= 1'b1;
    end else if (access && req.read && (req.address == LINE_STATUS_ADDR)) begin
      overrun <= 1'b0;
    end
  end

  // receive pointers and occupancy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_rd    <= '0;
      rx_wr    <= '0;
      rx_count <= '0;
    end else if (flush) begin
      rx_rd    <= '0;                                  // fifo enable change empties fifo
      rx_wr    <= '0;
      rx_count <= '0;
    end else begin
      if (rx_pop) begin
        rx_rd <= next_ptr(rx_rd);
      end
      if (rx_push) begin
        rx_wr <= next_ptr(rx_wr);
      end
      rx_count <= rx_count + CNT_W'(rx_push) - CNT_W'(rx_pop);
    end
  end

  // receive storage: tail write, or overwrite of the unread byte
  // without fifos the capacity is one, so the unread byte sits at the head
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        rx_mem[i] <= BYTE_RESET;
      end
    end else if (rx_push) begin
      rx_mem[rx_wr] <= rx_in.data;
    end else if (rx_overrun && !fifo_en) begin
      rx_mem[rx_rd] <= rx_in.data;
    end
  end

  // transmit pointers and occupancy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_rd    <= '0;
      tx_wr    <= '0;
      tx_count <= '0;
    end else if (flush) begin
      tx_rd    <= '0;
      tx_wr    <= '0;
      tx_count <= '0;
    end else begin
      if (tx_load) begin
        tx_rd <= next_ptr(tx_rd);
      end
      if (tx_push) begin
        tx_wr <= next_ptr(tx_wr);
      end
      tx_count <= tx_count + CNT_W'(tx_push) - CNT_W'(tx_load);
    end
  end

  // transmit storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        tx_mem[i] <= BYTE_RESET;
      end
    end else if (tx_push) begin
      tx_mem[tx_wr] <= req.writedata[7:0];
    end
  end

  // outgoing byte: holding register without fifo, fifo head with it
  // without fifos a second write simply replaces the pending byte;
  // with them the head moves out when the register is free or taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_data  <= BYTE_RESET;
      tx_valid <= 1'b0;
    end else if (flush) begin
      tx_valid <= 1'b0;                                // drop pending byte on fifo enable change
    end else if (!fifo_en && tx_hit) begin
      tx_data  <= req.writedata[7:0];
      tx_valid <= 1'b1;
    end else if (tx_load) begin
      tx_data  <= tx_mem[tx_rd];
      tx_valid <= 1'b1;
    end else if (tx_take) begin
      tx_valid <= 1'b0;                                // serializer took it
    end
  end

  // line selection for the serializer and the empty-edge detector
  // the detector resets high to match tx_holding_empty after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_to_infrared <= 1'b0;
      tx_empty_prev  <= 1'b1;
    end else begin
      tx_to_infrared <= infrared;
      tx_empty_prev  <= tx_empty;
    end
  end

endmodule // shadow_rx_tx_buffer

`default_nettype wire

//--- tb/far_end_model.sv
// far side model: remote transceiver sending bytes and draining transmit
// assumes one clock; bench drives stall to hold the drain back
`timescale 1ns/1ns
`default_nettype none
module far_end_model
  import shadow_buffer_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // towards the block
  output var  rx_byte_type uart_rx,
  output var  rx_byte_type ir_rx,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  input  wire logic        tx_to_infrared,
  output var  logic        tx_take,
  // bench control
  input  wire logic        stall
);
  logic [8:0] got[$];  // taken bytes, bit 8 marks infrared route
  initial begin
    uart_rx = '0;
    ir_rx = '0;
  end
  // one-cycle byte pulse, then data turns over so stale bytes never match
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge clk);
    if (ir) ir_rx <= '{1'b1, b};
    else uart_rx <= '{1'b1, b};
    @(posedge clk);
    uart_rx <= '{1'b0, ~b};
    ir_rx <= '{1'b0, ~b};
  endtask
  // drain: take a pending byte every other cycle unless stalled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_take <= 1'b0;
    end else begin
      tx_take <= tx_valid && !stall && !tx_take;
      if (tx_valid && tx_take) got.push_back({tx_to_infrared, tx_data});
    end
  end
endmodule  // far_end_model
`default_nettype wire

//--- tb/shadow_buffer_monitor.sv
// checker for the shadow buffer block, bound to its top ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ns
`default_nettype none
module shadow_buffer_monitor
  import shadow_buffer_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF  // fifo depth of the bound block
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // bus side
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0]        byteenable,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic              waitrequest,
  // transmit side
  input wire logic [7:0]        tx_data,
  input wire logic              tx_valid,
  input wire logic              tx_to_infrared,
  input wire logic              tx_take
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic wr_t, rd_t, hit, mapped, ctl;  // decoded bus events
  logic fifo_on, ir_want;              // mirrors of the control bits
  assign wr_t = write && waitrequest;
  assign rd_t = read && waitrequest;
  assign hit = address >= SHADOW_BASE && address <= SHADOW_LAST && address[1:0] == 2'b00;
  assign mapped = hit || address inside {CONTROL_ADDR, LINE_STATUS_ADDR,
                                         INT_STATUS_ADDR, INT_MASK_ADDR};
  assign ctl = wr_t && address == CONTROL_ADDR && byteenable[0];
  // follow control writes to know the mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_on <= 1'b0;
      ir_want <= 1'b0;
    end else if (ctl) begin
      fifo_on <= writedata[CTRL_FIFO_EN];
      ir_want <= writedata[CTRL_INFRARED];
    end
  end
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_read_hold: assert property (!rd_t |=> $stable(readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_t && !mapped |=> readdata == READ_ZERO)
    else $error("unmapped read not zero");
  a_ir_route: assert property (ctl |-> ##[1:2] tx_to_infrared == ir_want)
    else $error("infrared route does not follow control");
  a_direct_load: assert property (wr_t && hit && byteenable[0] && !fifo_on
    |=> tx_valid && tx_data == $past(writedata[7:0]))
    else $error("direct transmit byte not loaded");
  a_tx_hold: assert property (tx_valid && !tx_take && !wr_t |=> tx_valid && $stable(tx_data))
    else $error("pending transmit byte lost");
  a_take_clear: assert property (!fifo_on && tx_valid && tx_take && !wr_t |=> !tx_valid)
    else $error("taken byte still pending");
endmodule  // shadow_buffer_monitor
`default_nettype wire

//--- tb/shadow_rx_tx_buffer_tb.sv
// self-checking bench for the shadow buffer block
// assumes the far end model and the bound checker beside it
`timescale 1ns/1ns
`default_nettype none
module shadow_rx_tx_buffer_tb;
  import shadow_buffer_pkg::*;
  localparam int D = 4;               // small fifo depth
  logic              clk = 1'b0;      // 125 MHz clock
  logic              rst_b = 1'b0;    // active-low reset
  logic [ADDR_W-1:0] address = '0;    // bus request fields
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0]        byteenable = 4'hf;
  logic [DATA_W-1:0] readdata, r;     // read data and last taken word
  logic              waitrequest, irq, tx_valid, tx_to_infrared, tx_take;
  logic              stall = 1'b1;    // holds the far drain back
  logic [7:0]        tx_data;
  rx_byte_type       uart_rx, ir_rx;
  int                mismatches = 0, n_tests = 0;
  typedef struct packed {logic wr; logic [31:0] a, d, e;} row_type;
  // reset values, mask access and an unmapped place
  row_type rows[9] = '{'{1'b0, CONTROL_ADDR, 32'h0, 32'h0},
    '{1'b0, LINE_STATUS_ADDR, 32'h0, 32'h20}, '{1'b0, INT_STATUS_ADDR, 32'h0, 32'h0},
    '{1'b0, INT_MASK_ADDR, 32'h0, 32'h0}, '{1'b0, SHADOW_2_ADDR, 32'h0, 32'h0},
    '{1'b1, 32'h50001190, 32'hffffffff, 32'h0}, '{1'b0, 32'h50001190, 32'h0, 32'h0},
    '{1'b1, INT_MASK_ADDR, 32'h3f, 32'h0}, '{1'b0, INT_MASK_ADDR, 32'h0, 32'h3f}};
  always #4 clk = ~clk;
  shadow_rx_tx_buffer #(.DEPTH(D)) DUT (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .uart_rx(uart_rx),
    .ir_rx(ir_rx), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_to_infrared(tx_to_infrared), .tx_take(tx_take));
  far_end_model far (.clk(clk), .rst_b(rst_b), .uart_rx(uart_rx), .ir_rx(ir_rx),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_to_infrared(tx_to_infrared),
    .tx_take(tx_take), .stall(stall));
  // verdict and end of run
  task automatic wrap_up();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] be);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= w;
    read <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      mismatches++;
      wrap_up();
    end else begin
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  // read and compare
  task automatic rd(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(r, e);
  endtask
  // wait for the far end to hold n bytes
  task automatic wait_got(input int n);
    for (int k = 0; k < 200 && far.got.size() < n; k++) @(posedge clk);
    if (far.got.size() < n) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // reset held 8 cycles, outputs checked inside it
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    chk({28'h0, waitrequest, irq, tx_valid, tx_to_infrared}, 32'h8);
    chk(readdata, 32'h0);
    rst_b <= 1'b1;
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, 4'hf);
      if (!rows[i].wr) chk(r, rows[i].e);
    end
    // fifos off: receive, then overwrite with overrun
    far.send(1'b0, 8'h5a);
    rd(LINE_STATUS_ADDR, 32'h21);
    rd(SHADOW_2_ADDR, 32'h5a);
    far.send(1'b0, 8'h11);
    far.send(1'b0, 8'h22);
    rd(LINE_STATUS_ADDR, 32'h23);
    rd(SHADOW_3_ADDR, 32'h22);
    rd(LINE_STATUS_ADDR, 32'h20);
    // fifos off: lane-off write ignored, second write overwrites
    bus(1'b1, SHADOW_2_ADDR, 32'h1a5, 4'he);
    rd(LINE_STATUS_ADDR, 32'h20);
    bus(1'b1, SHADOW_2_ADDR, 32'hffffffa1, 4'hf);
    rd(LINE_STATUS_ADDR, 32'h00);
    bus(1'b1, SHADOW_3_ADDR, 32'ha2, 4'hf);
    stall <= 1'b0;
    wait_got(1);
    chk(far.got[0], 32'h0a2);
    // infrared mode: uart byte ignored, transmit routed
    bus(1'b1, CONTROL_ADDR, 32'h2, 4'hf);
    far.send(1'b0, 8'h99);
    far.send(1'b1, 8'h3c);
    rd(SHADOW_2_ADDR, 32'h3c);
    rd(LINE_STATUS_ADDR, 32'h20);
    bus(1'b1, SHADOW_2_ADDR, 32'h77, 4'hf);
    wait_got(2);
    chk(far.got[1], 32'h177);
    // fifos on: overfill receive, read head over aliases
    bus(1'b1, CONTROL_ADDR, 32'h1, 4'hf);
    stall <= 1'b1;
    for (int i = 0; i <= D; i++) far.send(1'b0, 8'(i) + 8'h40);
    rd(LINE_STATUS_ADDR, 32'h23);
    for (int i = 0; i < D; i++) rd(SHADOW_LAST - 32'(4 * i), 32'(i) + 32'h40);
    rd(LINE_STATUS_ADDR, 32'h20);
    // fifos on: overfill transmit while the far end stalls
    for (int i = 0; i < D + 2; i++) bus(1'b1, SHADOW_2_ADDR, 32'(i) + 32'h80, 4'hf);
    stall <= 1'b0;
    wait_got(2 + D);
    for (int i = 0; i < D; i++) chk(far.got[2 + i], 32'(i) + 32'h80);
    rd(LINE_STATUS_ADDR, 32'h20);
    chk(far.got.size(), 2 + D);
    // interrupt: masked, unmasked, cleared by read
    rd(INT_STATUS_ADDR, 32'h23);
    bus(1'b1, INT_MASK_ADDR, 32'h2, 4'hf);
    far.send(1'b0, 8'h5e);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, INT_MASK_ADDR, 32'h1, 4'hf);
    rd(INT_MASK_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(INT_STATUS_ADDR, 32'h1);
    rd(INT_STATUS_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // second reset with a byte pending
    stall <= 1'b1;
    bus(1'b1, SHADOW_2_ADDR, 32'h55, 4'hf);
    do_reset();
    rd(CONTROL_ADDR, 32'h0);
    rd(LINE_STATUS_ADDR, 32'h20);
    wrap_up();
  end
endmodule  // shadow_rx_tx_buffer_tb
bind shadow_rx_tx_buffer shadow_buffer_monitor #(.DEPTH(DEPTH)) mon (.clk(clk),
  .rst_b(rst_b), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_to_infrared(tx_to_infrared),
  .tx_take(tx_take));
`default_nettype wire
